// ### src/piac_top.sv
`timescale 1ns/100ps
module piac_top (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // Supply monitors and threshold comparators
  input wire piac_pkg::piac_supply_t SUPPLY_I,
  input wire piac_pkg::piac_cmp_t CMP_I,
  // Nonvolatile store, data one cycle after the read strobe
  output logic NVS_RD_O,
  output logic [2:0] NVS_IDX_O,
  input wire logic [15:0] NVS_DATA_I,
  // Strap converter
  output logic ADC_START_O,
  input wire logic ADC_DONE_I,
  input wire logic [9:0] ADC_CODE_I,
  input wire logic STRAP_FLOAT_I,
  // Input voltage telemetry
  input wire logic VIN_SAMPLE_I,
  input wire logic [9:0] VIN_CODE_I,
  output logic [9:0] READ_VIN_O,
  // Host register writes
  input wire logic WR_I,
  input wire logic [2:0] WR_IDX_I,
  input wire logic [15:0] WR_DATA_I,
  output logic WR_ACK_O,
  // Bus address match
  input wire logic ADDR_VALID_I,
  input wire logic [6:0] ADDR_I,
  output logic TW_HIT_O,
  output logic PM_HIT_O,
  // Tracking select
  input wire logic TRACK_LOW_I,
  output logic TRACK_MODE_O,
  // Status
  output logic POR_N_O,
  output logic LOAD_DONE_O,
  output logic STRAP_DONE_O,
  output logic ANALOG_MODE_O,
  output logic [2:0] PIN_ANALOG_O,
  output logic [6:0] TW_ADDR_O,
  output logic [6:0] PM_ADDR_O,
  output logic TW_EN_O,
  output logic PM_EN_O,
  output logic CONVERT_EN_O,
  output logic VIN_OK_O,
  output logic VIN_OV_FAULT_O,
  output logic VIN_UV_WARN_O,
  // Comparator thresholds
  output logic [15:0] VIN_ON_LVL_O,
  output logic [15:0] VIN_OFF_LVL_O,
  output logic [15:0] OV_LIM_O,
  output logic [15:0] UV_LIM_O
);
  piac_pkg::piac_state_t state;
  logic [15:0] work_reg [piac_pkg::NVS_WORDS];
  logic cap_vld;
  logic [2:0] cap_idx;
  logic [3:0] offset;
  logic supplies_ok;
  logic wr_ok;
  logic pin_cond;
  logic en_cond;
  logic [15:0] on_off;

  assign supplies_ok = SUPPLY_I.bias_ok & SUPPLY_I.core_ok & SUPPLY_I.osc_ok;
  assign on_off = work_reg[piac_pkg::IDX_ON_OFF];
  // Writes only in run state and only while the bus pins serve the bus
  assign wr_ok = WR_I && state == piac_pkg::ST_RUN && !ANALOG_MODE_O &&
                 WR_IDX_I <= piac_pkg::IDX_LAST; // R03 R13
  // Pin enable from the enable comparator alone; the bus lockout is applied at the conversion gate
  assign pin_cond = CMP_I.en_above;
  assign en_cond = (!ANALOG_MODE_O && on_off[piac_pkg::ONOFF_SW_SEL]) ?
                   on_off[piac_pkg::ONOFF_SW_ON] : pin_cond; // R14

  // Internal reset follows the supply and oscillator monitors
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      POR_N_O <= 1'b0;
    end else begin
      POR_N_O <= supplies_ok; // R01
    end
  end

  // Sequencer; any supply loss restarts the whole load
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state <= piac_pkg::ST_POR;
    end else if (!POR_N_O) begin
      state <= piac_pkg::ST_POR; // R01
    end else begin
      unique case (state)
        piac_pkg::ST_POR: begin
          state <= piac_pkg::ST_LOAD; // R02
        end
        piac_pkg::ST_LOAD: begin
          if (cap_vld && cap_idx == piac_pkg::IDX_LAST) begin
            state <= piac_pkg::ST_STRAP;
          end
        end
        piac_pkg::ST_STRAP: begin
          state <= piac_pkg::ST_STRAP_WAIT; // R08
        end
        piac_pkg::ST_STRAP_WAIT: begin
          if (ADC_DONE_I) begin
            state <= piac_pkg::ST_RUN;
          end
        end
        piac_pkg::ST_RUN: begin
          state <= piac_pkg::ST_RUN;
        end
      endcase
    end
  end

  // Store reads issued back to back, data captured a cycle later
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      NVS_RD_O <= 1'b0;
      NVS_IDX_O <= '0;
      cap_vld <= 1'b0;
      cap_idx <= '0;
    end else begin
      cap_vld <= NVS_RD_O;
      cap_idx <= NVS_IDX_O;
      if (state == piac_pkg::ST_POR && POR_N_O) begin
        NVS_RD_O <= 1'b1; // R02
        NVS_IDX_O <= '0;
      end else if (NVS_RD_O && NVS_IDX_O != piac_pkg::IDX_LAST && POR_N_O) begin
        NVS_IDX_O <= NVS_IDX_O + 3'h1;
      end else begin
        NVS_RD_O <= 1'b0;
      end
    end
  end

  // Working registers: store load first, host writes afterwards
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      work_reg[piac_pkg::IDX_TW_BASE] <= piac_pkg::RST_TW_BASE; // R07
      work_reg[piac_pkg::IDX_PM_BASE] <= piac_pkg::RST_PM_BASE; // R07
      work_reg[piac_pkg::IDX_ON_OFF] <= piac_pkg::RST_ON_OFF;
      work_reg[piac_pkg::IDX_VIN_ON] <= piac_pkg::RST_VIN_ON; // R15
      work_reg[piac_pkg::IDX_VIN_OFF] <= piac_pkg::RST_VIN_OFF; // R15
      work_reg[piac_pkg::IDX_OV_LIM] <= piac_pkg::RST_OV_LIM;
      work_reg[piac_pkg::IDX_UV_LIM] <= piac_pkg::RST_UV_LIM;
    end else if (cap_vld && state == piac_pkg::ST_LOAD) begin
      work_reg[cap_idx] <= NVS_DATA_I; // R02
    end else if (wr_ok) begin
      work_reg[WR_IDX_I] <= WR_DATA_I; // R03 R15
    end
  end

  // Write acknowledge, one cycle after an accepted write
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      WR_ACK_O <= 1'b0;
    end else begin
      WR_ACK_O <= wr_ok; // R03
    end
  end

  // Sequence flags, cleared whenever the internal reset drops
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      LOAD_DONE_O <= 1'b0;
      STRAP_DONE_O <= 1'b0;
      ADC_START_O <= 1'b0;
    end else if (!POR_N_O) begin
      LOAD_DONE_O <= 1'b0;
      STRAP_DONE_O <= 1'b0;
      ADC_START_O <= 1'b0;
    end else begin
      if (state == piac_pkg::ST_LOAD && cap_vld && cap_idx == piac_pkg::IDX_LAST) begin
        LOAD_DONE_O <= 1'b1; // R02
      end
      ADC_START_O <= state == piac_pkg::ST_STRAP; // R08
      if (state == piac_pkg::ST_STRAP_WAIT && ADC_DONE_I) begin
        STRAP_DONE_O <= 1'b1;
      end
    end
  end

  // Floating strap decided once, at the strap reading
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ANALOG_MODE_O <= 1'b0;
      PIN_ANALOG_O <= '0;
    end else if (state == piac_pkg::ST_STRAP_WAIT && ADC_DONE_I) begin
      ANALOG_MODE_O <= STRAP_FLOAT_I; // R12
      PIN_ANALOG_O <= STRAP_FLOAT_I ? piac_pkg::ANALOG_PINS : 3'h0; // R12
    end
  end

  piac_strap_decode u_strap (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .capture_i(state == piac_pkg::ST_STRAP_WAIT && ADC_DONE_I),
    .code_i(ADC_CODE_I),
    .offset_o(offset)
  );

  // Addresses and interface enables; sum wraps within 7 bits
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      TW_ADDR_O <= '0;
      PM_ADDR_O <= '0;
      TW_EN_O <= 1'b0;
      PM_EN_O <= 1'b0;
    end else begin
      TW_ADDR_O <= work_reg[piac_pkg::IDX_TW_BASE][6:0] + {3'h0, offset}; // R05 R07
      PM_ADDR_O <= work_reg[piac_pkg::IDX_PM_BASE][6:0] + {3'h0, offset}; // R05 R07
      TW_EN_O <= state == piac_pkg::ST_RUN && !ANALOG_MODE_O &&
                 work_reg[piac_pkg::IDX_TW_BASE][6:0] != 7'h00; // R06 R12
      PM_EN_O <= state == piac_pkg::ST_RUN && !ANALOG_MODE_O &&
                 work_reg[piac_pkg::IDX_PM_BASE][6:0] != 7'h00; // R06 R12
    end
  end

  // Address match for the bus front end
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      TW_HIT_O <= 1'b0;
      PM_HIT_O <= 1'b0;
    end else begin
      TW_HIT_O <= ADDR_VALID_I && TW_EN_O && ADDR_I == TW_ADDR_O; // R11
      PM_HIT_O <= ADDR_VALID_I && PM_EN_O && ADDR_I == PM_ADDR_O; // R11
    end
  end

  // Lockout with hysteresis from the two threshold comparators
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      VIN_OK_O <= 1'b0;
    end else if (CMP_I.vin_above_on) begin
      VIN_OK_O <= 1'b1; // R17
    end else if (!CMP_I.vin_above_off) begin
      VIN_OK_O <= 1'b0; // R17
    end
  end

  // Input faults straight from comparators, never from telemetry
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      VIN_OV_FAULT_O <= 1'b0;
      VIN_UV_WARN_O <= 1'b0;
    end else begin
      VIN_OV_FAULT_O <= POR_N_O && CMP_I.vin_ov; // R17
      VIN_UV_WARN_O <= POR_N_O && CMP_I.vin_uv; // R17
    end
  end

  // Conversion gate; internal reset drops it together with the sequence flags
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      CONVERT_EN_O <= 1'b0;
    end else begin
      CONVERT_EN_O <= POR_N_O && state == piac_pkg::ST_RUN && LOAD_DONE_O && STRAP_DONE_O &&
                      VIN_OK_O && en_cond; // R04 R14
    end
  end

  // Readback only; this value feeds nothing else
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      READ_VIN_O <= '0;
    end else if (VIN_SAMPLE_I) begin
      READ_VIN_O <= VIN_CODE_I; // R16
    end
  end

  // Tracking pin level as seen by start-up logic
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      TRACK_MODE_O <= 1'b0;
    end else begin
      TRACK_MODE_O <= TRACK_LOW_I; // R18
    end
  end

  // Thresholds handed to the analog comparators
  assign VIN_ON_LVL_O = work_reg[piac_pkg::IDX_VIN_ON];
  assign VIN_OFF_LVL_O = work_reg[piac_pkg::IDX_VIN_OFF];
  assign OV_LIM_O = work_reg[piac_pkg::IDX_OV_LIM];
  assign UV_LIM_O = work_reg[piac_pkg::IDX_UV_LIM];

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  a_por_supply: assert property (!supplies_ok |=> !POR_N_O ##1 state == piac_pkg::ST_POR) // R01
    else $error("reset not held on supply loss");
  a_load_done: assert property ($rose(LOAD_DONE_O) |-> $past(cap_vld) && // R02
    $past(cap_idx) == piac_pkg::IDX_LAST) else $error("load done without last word");
  a_write_gate: assert property (WR_ACK_O |-> $past(LOAD_DONE_O) && !$past(ANALOG_MODE_O)) // R03
    else $error("write accepted too early or in analog mode");
  a_convert_gate: assert property (CONVERT_EN_O |-> STRAP_DONE_O && LOAD_DONE_O && // R04
    $past(VIN_OK_O)) else $error("conversion without its conditions");
  a_zero_base_off: assert property (work_reg[piac_pkg::IDX_TW_BASE][6:0] == 7'h00 // R06
    |=> !TW_EN_O) else $error("zero base left interface on");
  a_addr_sum: assert property (1'b1 |=> PM_ADDR_O == 7'($past(work_reg[piac_pkg::IDX_PM_BASE][6:0]) // R07
    + {3'h0, $past(offset)})) else $error("address not base plus offset");
  a_hit_needs_en: assert property (TW_HIT_O |-> $past(TW_EN_O) && $past(ADDR_I) == $past(TW_ADDR_O)) // R11
    else $error("hit on wrong address");
  a_analog_quiet: assert property (ANALOG_MODE_O |-> !TW_EN_O && !PM_EN_O && !WR_ACK_O) // R12 R13
    else $error("bus active in analog mode");
  a_sw_enable_off: assert property (!ANALOG_MODE_O && on_off[piac_pkg::ONOFF_SW_SEL] && // R14
    !on_off[piac_pkg::ONOFF_SW_ON] |=> !CONVERT_EN_O) else $error("software off ignored");
  a_vin_isolated: assert property (!VIN_SAMPLE_I |=> $stable(READ_VIN_O)) // R16
    else $error("readback changed without sample");
  a_lockout_cmp: assert property (CMP_I.vin_above_on |=> VIN_OK_O) // R17
    else $error("lockout ignores comparator");
  a_por_rise: assert property (POR_N_O |-> $past(supplies_ok)) // R01
    else $error("internal reset released with a supply bad");
  // Store walk: strictly ascending, stops after the last slot
  a_walk_step: assert property (NVS_RD_O && POR_N_O && NVS_IDX_O != piac_pkg::IDX_LAST |=> // R02
    NVS_RD_O && NVS_IDX_O == $past(NVS_IDX_O) + 3'h1) else $error("store walk skipped a slot");
  a_walk_stop: assert property (NVS_RD_O && NVS_IDX_O == piac_pkg::IDX_LAST |=> !NVS_RD_O) // R02
    else $error("store read ran past the last slot");
  a_ack_in_run: assert property (WR_ACK_O |-> $past(state) == piac_pkg::ST_RUN) // R03
    else $error("write acknowledged outside run state");
  a_pm_zero_off: assert property (work_reg[piac_pkg::IDX_PM_BASE][6:0] == 7'h00 |=> !PM_EN_O) // R06
    else $error("zero base left interface on");
  // One start per strap read; a stuck start would restart the reading
  a_start_pulse: assert property (ADC_START_O |=> !ADC_START_O) // R08
    else $error("strap start longer than one cycle");
  a_analog_pins: assert property (ANALOG_MODE_O |-> PIN_ANALOG_O == piac_pkg::ANALOG_PINS) // R12
    else $error("analog mode without pin handover");
  // Analog mode keeps the loaded defaults, nothing may touch them
  a_analog_frozen: assert property (ANALOG_MODE_O && state == piac_pkg::ST_RUN |=> // R13
    $stable(VIN_ON_LVL_O) && $stable(VIN_OFF_LVL_O) && $stable(OV_LIM_O) && $stable(UV_LIM_O))
    else $error("working register changed in analog mode");
  a_ov_from_cmp: assert property (VIN_OV_FAULT_O |-> $past(POR_N_O) && $past(CMP_I.vin_ov)) // R17
    else $error("overvoltage fault without comparator");

  c_load_done: cover property ($rose(LOAD_DONE_O));
  c_convert_on: cover property ($rose(CONVERT_EN_O));
  c_analog: cover property ($rose(ANALOG_MODE_O));
  c_write: cover property (WR_ACK_O && TW_EN_O);
  c_write_refused: cover property (WR_I && state == piac_pkg::ST_RUN && !wr_ok);
endmodule

// ### src/piac_pkg.sv
// Behaviour
// (R01) Hold power-on reset until bias, core rail and oscillator are all good.
// (R02) After reset, copy every stored word into the working registers.
// (R03) Accept host writes once loading finishes, whatever the enable input says; the code accepts them only in ST_RUN, after the strap read.
// (R04) Convert only with enable, bus voltage, load done and strap read.
// (R05) Keep separate 7-bit two-wire and PMBus base address registers.
// (R06) A zero base address disables that bus interface.
// (R07) Bus address is stored base plus strap offset; defaults 0x10 and 0x40.
// (R08) Digitize the strap with a 10-bit converter into one of 16 offsets.
// (R09) Offsets ascend from +0 at 499 ohms to +15 at 11800 ohms.
// (R10) A reading between two nominal values takes the nearest offset.
// (R11) In digital mode answer commands sent to the computed address.
// (R12) Floating strap selects analog mode, ignores the bus, repurposes three pins.
// (R13) In analog mode the loaded configuration cannot be changed.
// (R14) In digital mode software enable options may replace the pin condition.
// (R15) Default bus lockout is 1 V; host may reprogram turn-on and turn-off.
// (R16) Digitized input voltage only feeds the input voltage readback.
// (R17) Lockout, overvoltage and undervoltage come from threshold comparators.
// (R18) System ties tracking pin low for tracking, pulls up for normal start.
package piac_pkg;
  // Working register slots, also the store word order
  localparam int NVS_WORDS = 7;
  localparam logic [2:0] IDX_TW_BASE = 3'h0;
  localparam logic [2:0] IDX_PM_BASE = 3'h1;
  localparam logic [2:0] IDX_ON_OFF = 3'h2;
  localparam logic [2:0] IDX_VIN_ON = 3'h3;
  localparam logic [2:0] IDX_VIN_OFF = 3'h4;
  localparam logic [2:0] IDX_OV_LIM = 3'h5;
  localparam logic [2:0] IDX_UV_LIM = 3'h6;
  localparam logic [2:0] IDX_LAST = 3'h6;
  // Reset values; voltages in 1/32 V steps, so 1 V is 0x20
  localparam logic [15:0] RST_TW_BASE = 16'h0010;
  localparam logic [15:0] RST_PM_BASE = 16'h0040;
  localparam logic [15:0] RST_ON_OFF = 16'h0000;
  localparam logic [15:0] RST_VIN_ON = 16'h0020;
  localparam logic [15:0] RST_VIN_OFF = 16'h0020;
  localparam logic [15:0] RST_OV_LIM = 16'h0300;
  localparam logic [15:0] RST_UV_LIM = 16'h0000;
  // Enable option fields
  localparam int ONOFF_SW_SEL = 0;
  localparam int ONOFF_SW_ON = 1;
  // Widths
  localparam int ADDR_W = 7;
  localparam int ADC_W = 10;
  localparam int OFS_W = 4;
  localparam int NUM_OFS = 16;
  // Strap resistor nominals and converter scale
  localparam int STRAP_OHM [16] = '{499, 1050, 1540, 2050, 2610, 3240, 3830, 4530,
                                    5230, 6040, 6980, 7870, 8870, 9760, 10700, 11800};
  localparam int ADC_OHM_PER_LSB = 12;
  localparam logic [2:0] ANALOG_PINS = 3'h7;

  typedef struct packed {
    logic bias_ok;
    logic core_ok;
    logic osc_ok;
  } piac_supply_t;

  typedef struct packed {
    logic en_above;
    logic vin_above_on;
    logic vin_above_off;
    logic vin_ov;
    logic vin_uv;
  } piac_cmp_t;

  typedef enum logic [2:0] {ST_POR, ST_LOAD, ST_STRAP, ST_STRAP_WAIT, ST_RUN} piac_state_t;
endpackage

// ### src/piac_strap_decode.sv
`timescale 1ns/100ps
module piac_strap_decode (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Converter reading
  input wire logic capture_i,
  input wire logic [piac_pkg::ADC_W-1:0] code_i,
  // Offset
  output logic [piac_pkg::OFS_W-1:0] offset_o
);
  logic [piac_pkg::NUM_OFS-2:0] above;
  logic [piac_pkg::OFS_W-1:0] next_offset;

  // Midpoints between neighbours; ties go to the lower offset
  for (genvar i = 0; i < piac_pkg::NUM_OFS - 1; i++) begin : g_mid
    localparam int MID = (piac_pkg::STRAP_OHM[i] + piac_pkg::STRAP_OHM[i+1]) /
                         (2 * piac_pkg::ADC_OHM_PER_LSB);
    assign above[i] = code_i > MID[piac_pkg::ADC_W-1:0]; // R10
  end

  // Count of midpoints passed is the ascending offset
  always_comb begin
    next_offset = '0;
    for (int i = 0; i < piac_pkg::NUM_OFS - 1; i++) begin
      next_offset = next_offset + {3'h0, above[i]}; // R09
    end
  end

  // Offset held from the one reading taken at start-up
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      offset_o <= '0;
    end else if (capture_i) begin
      offset_o <= next_offset; // R08
    end
  end

  a_low_code_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R09
    capture_i && !above[0] |=> offset_o == 4'h0) else $error("low strap not offset zero");
endmodule

// ### verification/piac_far_model.sv
`timescale 1ns/100ps
module piac_far_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Store side
  input wire logic rd_i,
  input wire logic [2:0] idx_i,
  input wire logic [6:0][15:0] words_i,
  output logic [15:0] data_o,
  // Strap converter side
  input wire logic start_i,
  input wire logic [7:0] delay_i,
  input wire logic [9:0] code_i,
  input wire logic float_i,
  output logic done_o,
  output logic [9:0] code_o,
  output logic float_o
);
  logic busy;
  logic [7:0] cnt;
  // Word one cycle after strobe; toggles otherwise so stale data never looks valid
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) data_o <= 16'h5a5a;
    else if (rd_i) data_o <= words_i[idx_i];
    else data_o <= ~data_o;
  end
  // Done comes delay_i+2 cycles after start; code and float valid only with done
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      done_o <= 1'b0;
      code_o <= 10'h155;
      float_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      code_o <= ~code_o;
      float_o <= ~float_o;
      if (start_i) begin
        busy <= 1'b1;
        cnt <= delay_i;
      end else if (busy && cnt != 8'h00) cnt <= cnt - 8'h01;
      else if (busy) begin
        busy <= 1'b0;
        done_o <= 1'b1;
        code_o <= code_i;
        float_o <= float_i;
      end
    end
  end
endmodule

// ### verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic CLK_I, ARST_N_I, NVS_RD_O, ADC_START_O, ADC_DONE_I, STRAP_FLOAT_I, VIN_SAMPLE_I, WR_I, WR_ACK_O;
  logic ADDR_VALID_I, TW_HIT_O, PM_HIT_O, TRACK_LOW_I, TRACK_MODE_O, POR_N_O, LOAD_DONE_O, STRAP_DONE_O;
  logic ANALOG_MODE_O, TW_EN_O, PM_EN_O, CONVERT_EN_O, VIN_OK_O, VIN_OV_FAULT_O, VIN_UV_WARN_O;
  logic [2:0] NVS_IDX_O, WR_IDX_I, PIN_ANALOG_O;
  logic [9:0] ADC_CODE_I, VIN_CODE_I, READ_VIN_O, strap_code;
  logic [15:0] NVS_DATA_I, WR_DATA_I, VIN_ON_LVL_O, VIN_OFF_LVL_O, OV_LIM_O, UV_LIM_O;
  logic [6:0] ADDR_I, TW_ADDR_O, PM_ADDR_O;
  logic [6:0][15:0] store;
  logic [7:0] adc_delay;
  logic strap_float, ten, pen;
  piac_pkg::piac_supply_t SUPPLY_I;
  piac_pkg::piac_cmp_t CMP_I;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  typedef struct {
    logic [9:0] code;
    logic flt;
    logic [7:0] dly;
    logic [6:0] tw, pm, exp_tw, exp_pm;
    logic ana;
  } piac_row_t;
  // Strap code, float, converter delay, bases, expected addresses, analog
  piac_row_t rows [8] = '{
    '{10'h029, 1'b0, 8'h00, 7'h10, 7'h40, 7'h10, 7'h40, 1'b0},
    '{10'h040, 1'b0, 8'h28, 7'h10, 7'h40, 7'h10, 7'h40, 1'b0},
    '{10'h041, 1'b0, 8'h03, 7'h10, 7'h40, 7'h11, 7'h41, 1'b0},
    '{10'h3d7, 1'b0, 8'h00, 7'h10, 7'h40, 7'h1f, 7'h4f, 1'b0},
    '{10'h3ff, 1'b0, 8'h05, 7'h10, 7'h40, 7'h1f, 7'h4f, 1'b0},
    '{10'h1d6, 1'b0, 8'h01, 7'h00, 7'h40, 7'h09, 7'h49, 1'b0},
    '{10'h100, 1'b1, 8'h02, 7'h10, 7'h40, 7'h10, 7'h40, 1'b1},
    '{10'h3d7, 1'b0, 8'h28, 7'h10, 7'h7a, 7'h1f, 7'h09, 1'b0}};

  piac_top piac_top_inst (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .SUPPLY_I(SUPPLY_I), .CMP_I(CMP_I),
    .NVS_RD_O(NVS_RD_O), .NVS_IDX_O(NVS_IDX_O), .NVS_DATA_I(NVS_DATA_I), .ADC_START_O(ADC_START_O),
    .ADC_DONE_I(ADC_DONE_I), .ADC_CODE_I(ADC_CODE_I), .STRAP_FLOAT_I(STRAP_FLOAT_I),
    .VIN_SAMPLE_I(VIN_SAMPLE_I), .VIN_CODE_I(VIN_CODE_I), .READ_VIN_O(READ_VIN_O), .WR_I(WR_I),
    .WR_IDX_I(WR_IDX_I), .WR_DATA_I(WR_DATA_I), .WR_ACK_O(WR_ACK_O), .ADDR_VALID_I(ADDR_VALID_I),
    .ADDR_I(ADDR_I), .TW_HIT_O(TW_HIT_O), .PM_HIT_O(PM_HIT_O), .TRACK_LOW_I(TRACK_LOW_I),
    .TRACK_MODE_O(TRACK_MODE_O), .POR_N_O(POR_N_O), .LOAD_DONE_O(LOAD_DONE_O), .STRAP_DONE_O(STRAP_DONE_O),
    .ANALOG_MODE_O(ANALOG_MODE_O), .PIN_ANALOG_O(PIN_ANALOG_O), .TW_ADDR_O(TW_ADDR_O), .PM_ADDR_O(PM_ADDR_O),
    .TW_EN_O(TW_EN_O), .PM_EN_O(PM_EN_O), .CONVERT_EN_O(CONVERT_EN_O), .VIN_OK_O(VIN_OK_O),
    .VIN_OV_FAULT_O(VIN_OV_FAULT_O), .VIN_UV_WARN_O(VIN_UV_WARN_O), .VIN_ON_LVL_O(VIN_ON_LVL_O),
    .VIN_OFF_LVL_O(VIN_OFF_LVL_O), .OV_LIM_O(OV_LIM_O), .UV_LIM_O(UV_LIM_O));
  piac_far_model piac_far_model_inst (.clk_i(CLK_I), .arst_n_i(ARST_N_I), .rd_i(NVS_RD_O), .idx_i(NVS_IDX_O),
    .words_i(store), .data_o(NVS_DATA_I), .start_i(ADC_START_O), .delay_i(adc_delay), .code_i(strap_code),
    .float_i(strap_float), .done_o(ADC_DONE_I), .code_o(ADC_CODE_I), .float_o(STRAP_FLOAT_I));

  // 25 MHz clock
  initial begin
    CLK_I = 1'b0;
    forever #20 CLK_I = ~CLK_I;
  end
  // Hang guard, far above the longest expected run
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask
  // Bounded wait: 0 reset release, 1 load done, 2 strap done
  task automatic wait_sig(input int k);
    int n;
    n = 0;
    while (n < 300 && !(k == 0 ? POR_N_O === 1'b1 : k == 1 ? LOAD_DONE_O === 1'b1 : STRAP_DONE_O === 1'b1)) begin
      tick(1);
      n++;
    end
  endtask
  task automatic wr(input logic [2:0] ix, input logic [15:0] d, input logic ack);
    tick(1);
    WR_I = 1'b1;
    WR_IDX_I = ix;
    WR_DATA_I = d;
    tick(1);
    WR_I = 1'b0;
    chk("wr_ack", ack, WR_ACK_O);
  endtask
  task automatic probe(input logic [6:0] a, input logic etw, input logic epm);
    tick(1);
    ADDR_VALID_I = 1'b1;
    ADDR_I = a;
    tick(1);
    ADDR_VALID_I = 1'b0;
    chk("tw_hit", etw, TW_HIT_O);
    chk("pm_hit", epm, PM_HIT_O);
  endtask
  // Full supply cycle, then watch the store walk and the strap read
  task automatic powerup(input piac_row_t rw);
    store[0] = {9'h000, rw.tw};
    store[1] = {9'h000, rw.pm};
    strap_code = rw.code;
    strap_float = rw.flt;
    adc_delay = rw.dly;
    tick(1);
    SUPPLY_I = 3'b000;
    tick(1);
    SUPPLY_I = 3'b111;
    wait_sig(0);
    chk("por", 1'b1, POR_N_O);
    for (int i = 0; i < 7; i++) begin
      tick(1);
      chk("nvs_rd", 1'b1, NVS_RD_O);
      chk("nvs_idx", 16'(i), NVS_IDX_O);
    end
    tick(1);
    chk("nvs_stop", 1'b0, NVS_RD_O);
    wait_sig(1);
    chk("load_done", 1'b1, LOAD_DONE_O);
    chk("vin_on", store[3], VIN_ON_LVL_O);
    chk("vin_off", store[4], VIN_OFF_LVL_O);
    chk("ov_lim", store[5], OV_LIM_O);
    chk("uv_lim", store[6], UV_LIM_O);
    chk("conv_early", 1'b0, CONVERT_EN_O);
    tick(1);
    chk("adc_start", 1'b1, ADC_START_O);
    wait_sig(2);
    chk("strap_done", 1'b1, STRAP_DONE_O);
    tick(2);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    ARST_N_I = 1'b0;
    SUPPLY_I = 3'b000;
    CMP_I = 5'b00000;
    {VIN_SAMPLE_I, VIN_CODE_I, WR_I, WR_IDX_I, WR_DATA_I, ADDR_VALID_I, ADDR_I, TRACK_LOW_I} = '0;
    {strap_code, strap_float, adc_delay} = '0;
    store = {16'h0100, 16'h0280, 16'h0030, 16'h0040, 16'h0000, 16'h0040, 16'h0010};
    tick(2);
    ARST_N_I = 1'b1;
    // Strap table, zero bases, analog mode, address wrap
    foreach (rows[r]) begin
      powerup(rows[r]);
      ten = rows[r].tw != 7'h00 && !rows[r].ana;
      pen = rows[r].pm != 7'h00 && !rows[r].ana;
      chk("analog", rows[r].ana, ANALOG_MODE_O);
      chk("pins", {3{rows[r].ana}}, PIN_ANALOG_O);
      chk("tw_en", ten, TW_EN_O);
      chk("pm_en", pen, PM_EN_O);
      if (ten) chk("tw_addr", rows[r].exp_tw, TW_ADDR_O);
      if (pen) chk("pm_addr", rows[r].exp_pm, PM_ADDR_O);
      probe(rows[r].exp_tw, ten, 1'b0);
      probe(rows[r].exp_pm, 1'b0, pen);
      wr(3'h3, 16'h0077, !rows[r].ana);
      chk("vin_on_wr", rows[r].ana ? store[3] : 16'h0077, VIN_ON_LVL_O);
    end
    // Telemetry path, lockout hysteresis, enable options, faults
    VIN_SAMPLE_I = 1'b1;
    VIN_CODE_I = 10'h2a5;
    tick(1);
    VIN_SAMPLE_I = 1'b0;
    chk("read_vin", 16'h02a5, READ_VIN_O);
    chk("vin_ok_adc", 1'b0, VIN_OK_O);
    CMP_I = 5'b11000;
    tick(2);
    chk("vin_ok", 1'b1, VIN_OK_O);
    chk("conv", 1'b1, CONVERT_EN_O);
    CMP_I = 5'b10100;
    tick(2);
    chk("vin_hold", 1'b1, VIN_OK_O);
    CMP_I = 5'b00100;
    tick(2);
    chk("conv_en_low", 1'b0, CONVERT_EN_O);
    wr(3'h2, 16'h0003, 1'b1);
    tick(2);
    chk("conv_sw_on", 1'b1, CONVERT_EN_O);
    wr(3'h2, 16'h0001, 1'b1);
    tick(2);
    chk("conv_sw_off", 1'b0, CONVERT_EN_O);
    CMP_I = 5'b00011;
    tick(2);
    chk("ov", 1'b1, VIN_OV_FAULT_O);
    chk("uv", 1'b1, VIN_UV_WARN_O);
    chk("vin_off", 1'b0, VIN_OK_O);
    // Base rewrite, refused slot, zeroed base, ack width
    wr(3'h0, 16'h0020, 1'b1);
    tick(1);
    chk("ack_once", 1'b0, WR_ACK_O);
    chk("tw_new", 16'h002f, TW_ADDR_O);
    wr(3'h7, 16'h1234, 1'b0);
    wr(3'h1, 16'h0000, 1'b1);
    tick(1);
    chk("pm_off", 1'b0, PM_EN_O);
    TRACK_LOW_I = 1'b1;
    tick(2);
    chk("track", 1'b1, TRACK_MODE_O);
    // Any one supply short keeps internal reset
    foreach (rows[k]) if (k < 3) begin
      SUPPLY_I = 3'b000;
      tick(1);
      SUPPLY_I = ~(3'b001 << k);
      tick(4);
      chk("por_partial", 1'b0, POR_N_O);
    end
    ARST_N_I = 1'b0;
    tick(1);
    chk("rst_on", 16'h0020, VIN_ON_LVL_O);
    chk("rst_off", 16'h0020, VIN_OFF_LVL_O);
    chk("rst_por", 1'b0, POR_N_O);
    print_verdict();
  end
endmodule
